// file: flp_pkg.sv
// flp_pkg: constants for the fuse programmer controller
// assumes a 250 MHz i_mclk; analog levels are steered by select outputs
// Operation
// - leave unused array links intact
// - setup: supply low, address, pulse high, enable low
// - program cycle steps spaced by sequence delay
// - verify pulse; status high means blown
// - same term: new variable address, repeat
// - new term: both addresses, repeat
// - at most two attempts, pulse 0.3-0.5 ms
// - sequence delay 10 us, verify 1 us
package flp_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SEQ_DELAY_US = 10;
  localparam int unsigned FUSE_PULSE_US = 400;
  localparam int unsigned VERIFY_TIME_US = 1;
  localparam int unsigned SEQ_DELAY_CYC = SEQ_DELAY_US * CLK_MHZ;
  localparam int unsigned FUSE_PULSE_CYC = FUSE_PULSE_US * CLK_MHZ;
  localparam int unsigned VERIFY_CYC = VERIFY_TIME_US * CLK_MHZ;
  localparam int unsigned MAX_ATTEMPTS = 2;
  localparam int unsigned ROW_W = 6;
  localparam int unsigned COL_W = 6;
  localparam int unsigned CNT_W = 20;
  typedef enum logic [3:0] {
    FLP_IDLE, FLP_SETUP, FLP_PWR, FLP_EN_UP, FLP_FS_UP, FLP_PULSE,
    FLP_FS_DN, FLP_EN_DN, FLP_VGAP, FLP_VER, FLP_DONE
  } flp_state_t;
endpackage : flp_pkg

// file: flp_timer.sv
// flp_timer: loadable down counter giving one-cycle done pulse
// assumes load is a single-cycle pulse from the sequencer
`timescale 1ns/100ps
module flp_timer #(
  parameter int unsigned W = flp_pkg::CNT_W
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // control
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  // status
  output logic o_done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic run_q;
  logic run_d;
  always_comb
  begin
    cnt_d = cnt_q;
    run_d = run_q;
    o_done = run_q && (cnt_q == '0);
    if (i_load)
    begin
      cnt_d = i_count - W'(1);
      run_d = 1'b1;
    end
    else if (run_q)
    begin
      if (cnt_q == '0)
        run_d = 1'b0;
      else
        cnt_d = cnt_q - W'(1);
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end
endmodule : flp_timer

// file: flp_programmer.sv
// flp_programmer: drives the program-verify sequence of one fuse
// assumes external switches turn the level selects into analog levels
`timescale 1ns/100ps
module flp_programmer #(
  parameter int unsigned SEQ_CYC = flp_pkg::SEQ_DELAY_CYC,
  parameter int unsigned PULSE_CYC = flp_pkg::FUSE_PULSE_CYC,
  parameter int unsigned VER_CYC = flp_pkg::VERIFY_CYC,
  parameter int unsigned ATTEMPTS = flp_pkg::MAX_ATTEMPTS
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // user command
  input wire logic i_start,
  input wire logic [flp_pkg::ROW_W-1:0] i_row,
  input wire logic [flp_pkg::COL_W-1:0] i_col,
  output logic o_busy,
  output logic o_done,
  output logic o_pass,
  output logic [7:0] o_fail_count,
  // device pins
  output logic [flp_pkg::ROW_W-1:0] o_row_addr,
  output logic [flp_pkg::COL_W-1:0] o_col_addr,
  output logic o_addr_oe,
  output logic o_supply_program_sel,
  output logic o_fuse_supply_program_sel,
  output logic o_pulse_line,
  output logic o_program_enable_line,
  input wire logic i_verify_status_line
);
  flp_pkg::flp_state_t st_q, st_d;
  logic [flp_pkg::ROW_W-1:0] row_q, row_d;
  logic [flp_pkg::COL_W-1:0] col_q, col_d;
  logic [1:0] try_q, try_d;
  logic pass_q, pass_d;
  logic done_q, done_d;
  logic vcc_q, vcc_d;
  logic fsp_q, fsp_d;
  logic pls_q, pls_d;
  logic en_q, en_d;
  logic [7:0] fail_q, fail_d;
  logic ld;
  logic [flp_pkg::CNT_W-1:0] ld_cnt;
  logic tdone;

  flp_timer #(.W(flp_pkg::CNT_W)) u_timer (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_load(ld),
    .i_count(ld_cnt),
    .o_done(tdone)
  );

  always_comb
  begin
    st_d = st_q;
    row_d = row_q;
    col_d = col_q;
    try_d = try_q;
    pass_d = pass_q;
    done_d = 1'b0;
    vcc_d = vcc_q;
    fsp_d = fsp_q;
    pls_d = pls_q;
    en_d = en_q;
    fail_d = fail_q;
    ld = 1'b0;
    ld_cnt = flp_pkg::CNT_W'(SEQ_CYC);
    case (st_q)
      flp_pkg::FLP_IDLE:
        if (i_start)
        begin
          // a new address covers both same-term and new-term steps
          row_d = i_row;
          // only the commanded link is fused, every other stays intact
          col_d = i_col;
          try_d = 2'h0;
          pass_d = 1'b0;
          vcc_d = 1'b0;
          fsp_d = 1'b0;
          pls_d = 1'b1;
          en_d = 1'b0;
          ld = 1'b1;
          st_d = flp_pkg::FLP_SETUP;
        end
      flp_pkg::FLP_SETUP:
        if (tdone)
        begin
          vcc_d = 1'b1;
          ld = 1'b1;
          st_d = flp_pkg::FLP_PWR;
        end
      flp_pkg::FLP_PWR:
        if (tdone)
        begin
          en_d = 1'b1;
          ld = 1'b1;
          st_d = flp_pkg::FLP_EN_UP;
        end
      flp_pkg::FLP_EN_UP:
        if (tdone)
        begin
          fsp_d = 1'b1;
          ld = 1'b1;
          st_d = flp_pkg::FLP_FS_UP;
        end
      flp_pkg::FLP_FS_UP:
        if (tdone)
        begin
          pls_d = 1'b0;
          ld = 1'b1;
          ld_cnt = flp_pkg::CNT_W'(PULSE_CYC);
          try_d = try_q + 2'h1;
          st_d = flp_pkg::FLP_PULSE;
        end
      flp_pkg::FLP_PULSE:
        if (tdone)
        begin
          pls_d = 1'b1;
          ld = 1'b1;
          st_d = flp_pkg::FLP_FS_DN;
        end
      flp_pkg::FLP_FS_DN:
        if (tdone)
        begin
          fsp_d = 1'b0;
          ld = 1'b1;
          st_d = flp_pkg::FLP_EN_DN;
        end
      flp_pkg::FLP_EN_DN:
        if (tdone)
        begin
          en_d = 1'b0;
          ld = 1'b1;
          st_d = flp_pkg::FLP_VGAP;
        end
      flp_pkg::FLP_VGAP:
        if (tdone)
        begin
          pls_d = 1'b0;
          ld = 1'b1;
          ld_cnt = flp_pkg::CNT_W'(VER_CYC);
          st_d = flp_pkg::FLP_VER;
        end
      flp_pkg::FLP_VER:
        if (tdone)
        begin
          pls_d = 1'b1;
          ld = 1'b1;
          // sampled at end of verify time; low means not blown
          if (i_verify_status_line)
          begin
            pass_d = 1'b1;
            st_d = flp_pkg::FLP_DONE;
          end
          else if (32'(try_q) < ATTEMPTS)
            st_d = flp_pkg::FLP_PWR;
          else
          begin
            fail_d = fail_q + 8'h01;
            st_d = flp_pkg::FLP_DONE;
          end
        end
      flp_pkg::FLP_DONE:
        if (tdone)
        begin
          // supply dropped so the next address is set up cold
          vcc_d = 1'b0;
          done_d = 1'b1;
          st_d = flp_pkg::FLP_IDLE;
        end
      default:
        st_d = flp_pkg::FLP_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q <= flp_pkg::FLP_IDLE;
      row_q <= '0;
      col_q <= '0;
      try_q <= 2'h0;
      pass_q <= 1'b0;
      done_q <= 1'b0;
      vcc_q <= 1'b0;
      fsp_q <= 1'b0;
      pls_q <= 1'b1;
      en_q <= 1'b0;
      fail_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      row_q <= row_d;
      col_q <= col_d;
      try_q <= try_d;
      pass_q <= pass_d;
      done_q <= done_d;
      vcc_q <= vcc_d;
      fsp_q <= fsp_d;
      pls_q <= pls_d;
      en_q <= en_d;
      fail_q <= fail_d;
    end
  end

  assign o_busy = (st_q != flp_pkg::FLP_IDLE);
  assign o_done = done_q;
  assign o_pass = pass_q;
  assign o_fail_count = fail_q;
  assign o_row_addr = row_q;
  assign o_col_addr = col_q;
  assign o_addr_oe = o_busy;
  assign o_supply_program_sel = vcc_q;
  assign o_fuse_supply_program_sel = fsp_q;
  assign o_pulse_line = pls_q;
  assign o_program_enable_line = en_q;

  fuse_only_enabled_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    fsp_q |-> en_q && vcc_q)
    else $error("fuse supply without enable");
  pulse_needs_fuse_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_q == flp_pkg::FLP_PULSE) |-> !pls_q && fsp_q)
    else $error("program pulse without fuse supply");
  verify_pulse_low_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_q == flp_pkg::FLP_VER) |-> !pls_q && !en_q && !fsp_q)
    else $error("verify pulse state wrong");
  attempts_bounded_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    32'(try_q) <= ATTEMPTS)
    else $error("too many attempts");
  setup_levels_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_q == flp_pkg::FLP_SETUP) |-> !vcc_q && pls_q && !en_q && !fsp_q)
    else $error("setup levels wrong");
  addr_stable_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (o_busy && $past(o_busy)) |-> $stable(row_q) && $stable(col_q))
    else $error("address moved in cycle");
  fail_counted_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_q == flp_pkg::FLP_VER && tdone && !i_verify_status_line &&
     32'(try_q) >= ATTEMPTS) |=> fail_q == $past(fail_q) + 8'h01)
    else $error("failure not recorded");
  enable_step_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    $rose(en_q) |-> ##[1:2] (st_q == flp_pkg::FLP_EN_UP) && !fsp_q)
    else $error("enable step order wrong");
endmodule : flp_programmer

// file: flp_fuse_model.sv
// flp_fuse_model: behavioural fuse array as seen at the program pins
// assumes level selects stand for the analog supply levels
`timescale 1ns/100ps
module flp_fuse_model (
  // pins
  input wire logic i_mclk,
  input wire logic [5:0] i_row,
  input wire logic [5:0] i_col,
  input wire logic i_sup,
  input wire logic i_fs,
  input wire logic i_pulse,
  input wire logic i_en,
  // scenario: fusing attempts that fail on purpose
  input wire logic [1:0] i_refuse,
  output logic o_stat
);
  // one flat link map: input and line terms, polarity and direction links
  logic blown_q [0:4095];
  logic pul_q = 1'b1;
  logic sup_q = 1'b0;
  logic tog_q = 1'b0;
  logic [1:0] used_q = 2'h0;
  initial foreach (blown_q[k]) blown_q[k] = 1'b0; // virgin part
  always @(posedge i_mclk)
  begin
    pul_q <= i_pulse;
    sup_q <= i_sup;
    tog_q <= ~tog_q;
    if (i_sup && !sup_q)
      used_q <= 2'h0;
    if (i_sup && i_en && i_fs && pul_q && !i_pulse)
    begin
      if (used_q < i_refuse)
        used_q <= used_q + 2'h1;
      else
        blown_q[{i_row, i_col}] <= 1'b1; // one link per address
    end
  end
  // intact link reads low; outside verify the line wanders
  assign o_stat = (i_sup && !i_en && !i_fs && !i_pulse) ?
    blown_q[{i_row, i_col}] : tog_q;
endmodule : flp_fuse_model

// file: flp_programmer_bench.sv
// flp_programmer_bench: fuse operations against the fuse model
// assumes short timing parameters to keep the run small
`timescale 1ns/100ps
module flp_programmer_bench;
  localparam int S = 4;
  localparam int P = 8;
  localparam int V = 4;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [5:0] row = 6'h00;
  logic [5:0] col = 6'h00;
  logic [1:0] refuse = 2'h0;
  logic busy, done, pass, sup, fs, pul, en, oe, stat;
  logic [7:0] fcnt;
  logic [5:0] ra, ca;
  logic [3:0] pins_q = 4'h1;
  int n_fail = 0;
  int checks_done = 0;
  int gap = S;
  int nprog = 0;
  int nver = 0;
  int nbad = 0;
  always #2 mclk = ~mclk;
  flp_programmer #(.SEQ_CYC(S), .PULSE_CYC(P), .VER_CYC(V), .ATTEMPTS(2))
    i_flp_programmer (.i_mclk(mclk), .i_rst_n(rst_n), .i_start(start),
    .i_row(row), .i_col(col), .o_busy(busy), .o_done(done), .o_pass(pass),
    .o_fail_count(fcnt), .o_row_addr(ra), .o_col_addr(ca), .o_addr_oe(oe),
    .o_supply_program_sel(sup), .o_fuse_supply_program_sel(fs),
    .o_pulse_line(pul), .o_program_enable_line(en),
    .i_verify_status_line(stat));
  flp_fuse_model i_flp_fuse_model (.i_mclk(mclk), .i_row(ra), .i_col(ca),
    .i_sup(sup), .i_fs(fs), .i_pulse(pul), .i_en(en), .i_refuse(refuse),
    .o_stat(stat));
  // pin monitor: spacing and order of the program steps
  always @(posedge mclk)
  begin
    if (rst_n)
    begin
      pins_q <= {sup, fs, en, pul};
      if (!pul && fs) nprog <= nprog + 1;
      if (!pul && !fs) nver <= nver + 1;
      if ({sup, fs, en, pul} != pins_q)
      begin
        gap <= 1;
        if (gap < S) nbad <= nbad + 1;
        if (sup && !pins_q[3] && (en || fs || !pul))
          nbad <= nbad + 1;
        if (fs && !pins_q[2] && !en) nbad <= nbad + 1;
      end
      else
        gap <= gap + 1;
    end
  end
  task automatic check(input string what, input logic [31:0] got,
      input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // one fuse; a second start while busy must be ignored
  task automatic run_op(input string nm, input logic [5:0] r,
      input logic [5:0] c, input logic [1:0] rf, input logic ep,
      input int att, input logic [7:0] ef);
    int p0;
    int v0;
    int t;
    @(posedge mclk);
    p0 = nprog;
    v0 = nver;
    row <= r;
    col <= c;
    refuse <= rf;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    repeat (3) @(posedge mclk);
    row <= ~r;
    col <= ~c;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    @(negedge mclk);
    check({nm, " addr"}, {oe, ra, ca}, {1'b1, r, c});
    t = 0;
    while (done !== 1'b1 && t < 4000)
    begin
      @(negedge mclk);
      t++;
    end
    check({nm, " done"}, done, 1'b1);
    check({nm, " pass"}, pass, ep);
    check({nm, " fails"}, fcnt, ef);
    check({nm, " pulse"}, nprog - p0, att * P);
    check({nm, " verify"}, nver - v0, att * V);
    check({nm, " idle"}, {busy, sup, fs, en, pul}, 5'h01);
    @(negedge mclk);
    check({nm, " done once"}, done, 1'b0);
    $display("test %s finished", nm);
  endtask : run_op
  // reset held over eight rising edges, released by the eighth
  task automatic reset_test;
    repeat (7) @(posedge mclk);
    @(negedge mclk);
    check("reset flags", {busy, done, pass, fcnt}, 11'h000);
    check("reset pins", {pul, en, sup, fs, oe}, 5'h10);
    @(posedge mclk);
    rst_n <= 1'b1;
    $display("test reset finished");
  endtask : reset_test
  initial
  begin
    reset_test();
    run_op("first", 6'h01, 6'h02, 2'h0, 1'b1, 1, 8'h00);
    run_op("retry", 6'h02, 6'h02, 2'h1, 1'b1, 2, 8'h00);
    run_op("reject", 6'h05, 6'h09, 2'h2, 1'b0, 2, 8'h01);
    run_op("corner", 6'h3F, 6'h3F, 2'h3, 1'b0, 2, 8'h02);
    check("step order", nbad, 0);
    summarize();
  end
  initial
  begin
    #80000;
    $display("watchdog expired");
    n_fail++;
    summarize();
  end
endmodule : flp_programmer_bench
